// file: inc/cidb_defines.vh
// Constants for the CAN identifier buffer map block
`ifndef CIDB_DEFINES_VH
`define CIDB_DEFINES_VH

// Register byte offsets (one aligned word each)
`define CIDB_OFF_ID0 8'h00
`define CIDB_OFF_ID1 8'h04
`define CIDB_OFF_ID2 8'h08
`define CIDB_OFF_ID3 8'h0c
`define CIDB_OFF_STAT 8'h10
`define CIDB_OFF_SEL 8'h14
`define CIDB_OFF_TXID 8'h18
`define CIDB_OFF_RXID 8'h1c

// Field positions in identifier byte 1
`define CIDB_B1_SRR 4
`define CIDB_B1_IDE 3
`define CIDB_B1_SRTR 4

// Field position in identifier byte 3
`define CIDB_B3_RTR 0

// Flag encodings
`define CIDB_IDE_STD 1'b0
`define CIDB_IDE_EXT 1'b1
`define CIDB_RTR_DATA 1'b0
`define CIDB_RTR_REMOTE 1'b1

// Reset values of control state
`define CIDB_SEL_RST 8'h00
`define CIDB_RXF_RST 1'b0

// Buffer entries: transmit buffers first, then the receive buffer
`define CIDB_NTX 3
`define CIDB_NENT 4

`endif

// file: src/cidb_mem.v
// Small identifier byte store with registered read data
`timescale 1ns/1ns

module cidb_mem #(
	parameter AW = 4,
	parameter DW = 8
) (
	// Clock and enable
	input wire clk_i,
	input wire ce_i,
	// Write port
	input wire we_i,
	input wire [AW-1:0] waddr_i,
	input wire [DW-1:0] wdata_i,
	// Read port
	input wire [AW-1:0] raddr_i,
	output reg [DW-1:0] rdata_o
);

	// No reset: the contents start undefined like any RAM
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// ========================================
	// Write and registered read
	always @(posedge clk_i) begin
		if (ce_i) begin
			if (we_i) begin
				mem[waddr_i] <= wdata_i;
			end
			rdata_o <= mem[raddr_i];
		end
	end

endmodule // cidb_mem

// file: src/cidb_top.v
// Identifier bytes of CAN message buffers, Wishbone slave and engine port
`timescale 1ns/1ns
`include "cidb_defines.vh"

module cidb_top #(
	parameter NTX = `CIDB_NTX
) (
	// Clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	output reg err_o,
	// Flags from the rest of the controller
	input wire [NTX-1:0] tx_buffer_empty_flag_i,
	input wire rx_buffer_full_flag_set_i,
	// Receive store from the bit engine
	input wire rx_store_i,
	input wire [28:0] rx_id_i,
	input wire rx_ide_i,
	input wire rx_srr_i,
	input wire rx_rtr_i,
	// Transmit fetch request from the bit engine
	input wire tx_fetch_i,
	input wire [1:0] tx_fetch_buf_i,
	// Transmit identifier, arbitration-ordered, and the receive full flag
	output reg tx_valid_o,
	output reg [31:0] tx_arb_o,
	output reg [4:0] tx_arb_len_o,
	output reg rx_buffer_full_flag_o
);

	// ========================================
	// Declarations
	localparam ST_IDLE = 4'b0001;
	localparam ST_BRD = 4'b0010;
	localparam ST_BACK = 4'b0100;
	localparam ST_FETCH = 4'b1000;
	localparam RXE = 2'd3;

	reg [3:0] st_r;
	reg [3:0] st_nxt;
	reg [7:0] sel_r;
	reg [1:0] fbyte_r;
	reg [1:0] fbuf_r;
	reg fetch_pend_r;
	reg [31:0] asm_r;
	reg [1:0] rx_cnt_r;
	reg rx_busy_r;
	reg [31:0] rx_word_r;
	reg [1:0] bus_byte_r;
	reg [1:0] bus_buf_r;
	reg mem_we;
	reg [3:0] mem_wa;
	reg [7:0] mem_wd;
	reg [3:0] mem_ra;
	wire [7:0] mem_rd;
	wire [31:0] asm_full;
	wire bus_req;
	wire id_hit;
	wire [1:0] acc_byte;
	wire tx_ok;
	wire rx_ok;
	wire acc_ok;
	wire [1:0] cur_buf;
	reg [31:0] rx_pack;
	reg [31:0] arb_word;
	reg [4:0] arb_len;

	assign bus_req = cyc_i & stb_i & ~ack_o & ~err_o;
	assign id_hit = (adr_i[7:4] == 4'h0) & (adr_i[1:0] == 2'b00);
	assign acc_byte = adr_i[3:2];
	// Fetched word: three bytes already shifted in plus the one now read
	assign asm_full = {asm_r[23:0], mem_rd};

	// Lowest set selection bit picks the visible transmit buffer
	assign cur_buf = sel_r[0] ? 2'd0 : (sel_r[1] ? 2'd1 : 2'd2);

	// Window access gated by buffer state
	assign tx_ok = (sel_r[2:0] != 3'b000) &
		tx_buffer_empty_flag_i[cur_buf];
	assign rx_ok = rx_buffer_full_flag_o & ~we_i;
	assign acc_ok = tx_ok | rx_ok;

	// ========================================
	// Pack a received frame into the byte layout
	always @* begin
		rx_pack = 32'h00000000;
		if (rx_ide_i == `CIDB_IDE_EXT) begin
			rx_pack[31:24] = rx_id_i[28:21];
			rx_pack[23:21] = rx_id_i[20:18];
			rx_pack[16+`CIDB_B1_SRR] = rx_srr_i;
			rx_pack[16+`CIDB_B1_IDE] = `CIDB_IDE_EXT;
			rx_pack[18:16] = rx_id_i[17:15];
			rx_pack[15:8] = rx_id_i[14:7];
			rx_pack[7:1] = rx_id_i[6:0];
			rx_pack[`CIDB_B3_RTR] = rx_rtr_i;
		end else begin
			rx_pack[31:24] = rx_id_i[10:3];
			rx_pack[23:21] = rx_id_i[2:0];
			rx_pack[16+`CIDB_B1_SRTR] = rx_rtr_i;
			rx_pack[16+`CIDB_B1_IDE] = `CIDB_IDE_STD;
		end
	end

	// ========================================
	// Unpack a fetched buffer into arbitration order, MSB first
	// Left-justified so that a plain compare gives priority
	always @* begin
		arb_word = 32'h00000000;
		arb_len = 5'd0;
		if (asm_full[16+`CIDB_B1_IDE] == `CIDB_IDE_EXT) begin
			// ID28..18, SRR, IDE, ID17..0, RTR
			arb_word = {asm_full[31:21], asm_full[16+`CIDB_B1_SRR],
				1'b1, asm_full[18:16], asm_full[15:8], asm_full[7:1],
				asm_full[`CIDB_B3_RTR]};
			arb_len = 5'd31; // Bit count minus one: 32 bits
		end else begin
			// ID10..0, RTR, IDE, then unused bits not sent
			arb_word = {asm_full[31:21], asm_full[16+`CIDB_B1_SRTR],
				1'b0, 19'h0};
			arb_len = 5'd12; // Bit count minus one: 13 bits
		end
	end

	// ========================================
	// Memory port steering: receive store beats bus writes
	always @* begin
		mem_we = 1'b0;
		mem_wa = 4'h0;
		mem_wd = 8'h00;
		mem_ra = {bus_buf_r, bus_byte_r};
		if (rx_busy_r) begin
			mem_we = 1'b1;
			mem_wa = {RXE, rx_cnt_r};
			mem_wd = rx_word_r[8*(3-rx_cnt_r) +: 8];
		end else if (st_r == ST_IDLE && bus_req && !fetch_pend_r &&
			id_hit && we_i && sel_i[0] && tx_ok) begin
			mem_we = 1'b1;
			mem_wa = {cur_buf, acc_byte};
			mem_wd = dat_i[7:0];
		end
		if (st_r == ST_IDLE && fetch_pend_r) begin
			mem_ra = {fbuf_r, 2'd0};
		end else if (st_r == ST_FETCH) begin
			// Read is registered, so ask one byte ahead of the shift
			mem_ra = {fbuf_r, fbyte_r + 2'd1};
		end
	end

	cidb_mem #(
		.AW(4),
		.DW(8)
	) u_mem (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.we_i(mem_we),
		.waddr_i(mem_wa),
		.wdata_i(mem_wd),
		.raddr_i(mem_ra),
		.rdata_o(mem_rd)
	);

	// ========================================
	// Next state
	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (fetch_pend_r) begin
					st_nxt = ST_FETCH;
				end else if (bus_req && id_hit && !we_i && acc_ok &&
					!rx_busy_r) begin
					st_nxt = ST_BRD;
				end
			end
			ST_BRD: st_nxt = ST_BACK;
			ST_BACK: st_nxt = ST_IDLE;
			ST_FETCH: begin
				if (fbyte_r == 2'd3) begin
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// ========================================
	// Bus answers, selection, receive flag, fetch sequencing
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			sel_r <= `CIDB_SEL_RST;
			rx_buffer_full_flag_o <= `CIDB_RXF_RST;
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h00000000;
			fetch_pend_r <= 1'b0;
			fbyte_r <= 2'd0;
			fbuf_r <= 2'd0;
			asm_r <= 32'h00000000;
			rx_busy_r <= 1'b0;
			rx_cnt_r <= 2'd0;
			rx_word_r <= 32'h00000000;
			bus_byte_r <= 2'd0;
			bus_buf_r <= 2'd0;
			tx_valid_o <= 1'b0;
			tx_arb_o <= 32'h00000000;
			tx_arb_len_o <= 5'd0;
		end else if (ce_i) begin
			st_r <= st_nxt;
			ack_o <= 1'b0;
			err_o <= 1'b0;
			tx_valid_o <= 1'b0;
			// Receive store: four byte writes, full raised with the fourth
			if (rx_store_i && !rx_busy_r) begin
				rx_busy_r <= 1'b1;
				rx_cnt_r <= 2'd0;
				rx_word_r <= rx_pack;
			end else if (rx_busy_r) begin
				rx_cnt_r <= rx_cnt_r + 2'd1;
				if (rx_cnt_r == 2'd3) begin
					rx_busy_r <= 1'b0;
				end
			end
			// Full flag: hardware set beats software release
			if ((rx_busy_r && rx_cnt_r == 2'd3) ||
				rx_buffer_full_flag_set_i) begin
				rx_buffer_full_flag_o <= 1'b1;
			end else if (st_r == ST_IDLE && bus_req && !fetch_pend_r &&
				we_i && adr_i == `CIDB_OFF_STAT && sel_i[0] &&
				dat_i[0]) begin
				rx_buffer_full_flag_o <= 1'b0;
			end
			// Fetch request latched until the fetch sequence starts from idle
			if (tx_fetch_i && !fetch_pend_r && st_r != ST_FETCH) begin
				fetch_pend_r <= 1'b1;
				fbuf_r <= tx_fetch_buf_i;
				fbyte_r <= 2'd0;
			end
			if (st_r == ST_IDLE && fetch_pend_r) begin
				fetch_pend_r <= 1'b0;
			end
			if (st_r == ST_FETCH) begin
				fbyte_r <= fbyte_r + 2'd1;
				asm_r <= asm_full;
			end
			// Word and length move out together with the valid pulse
			if (st_r == ST_FETCH && fbyte_r == 2'd3) begin
				tx_valid_o <= 1'b1;
				tx_arb_o <= arb_word;
				tx_arb_len_o <= arb_len;
			end
			// Read address capture for window reads
			if (st_nxt == ST_BRD) begin
				bus_byte_r <= acc_byte;
				bus_buf_r <= rx_ok ? RXE : cur_buf;
			end
			// Register bus: writes and non-window reads in one cycle
			if (st_r == ST_IDLE && bus_req && !fetch_pend_r) begin
				if (id_hit) begin
					if (we_i && tx_ok && !rx_busy_r) begin
						ack_o <= 1'b1;
					end else if (!we_i && acc_ok && !rx_busy_r) begin
						ack_o <= 1'b0;
					end else if (!rx_busy_r) begin
						err_o <= 1'b1;
					end
				end else if (adr_i == `CIDB_OFF_STAT) begin
					ack_o <= 1'b1;
					dat_o <= {{(26-NTX){1'b0}}, tx_buffer_empty_flag_i,
						3'b000, tx_valid_o, st_r == ST_FETCH,
						rx_buffer_full_flag_o};
				end else if (adr_i == `CIDB_OFF_SEL) begin
					ack_o <= 1'b1;
					if (we_i && sel_i[0]) begin
						sel_r <= {5'b00000, dat_i[2:0]};
					end
					dat_o <= {24'h000000, sel_r};
				end else if (adr_i == `CIDB_OFF_TXID) begin
					ack_o <= 1'b1;
					dat_o <= tx_arb_o;
				end else if (adr_i == `CIDB_OFF_RXID) begin
					ack_o <= 1'b1;
					dat_o <= {27'h0, tx_arb_len_o};
				end else begin
					err_o <= 1'b1;
				end
			end
			// Window read data; bits above the byte read as zero
			if (st_r == ST_BACK) begin
				ack_o <= 1'b1;
				dat_o <= {24'h000000, mem_rd};
			end
		end
	end

endmodule // cidb_top

// file: bench/cidb_top_chk.sv
// Port checks for the identifier buffer block
`timescale 1ns/1ns
`include "cidb_defines.vh"
// ==============================
// Checker
module cidb_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	input wire logic err_o,
	// Engine and flags
	input wire logic rx_buffer_full_flag_set_i,
	input wire logic rx_buffer_full_flag_o,
	input wire logic [`CIDB_NTX-1:0] tx_buffer_empty_flag_i,
	input wire logic tx_fetch_i,
	input wire logic tx_valid_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Status write asking the full flag to drop
	wire clr_w = cyc_i && stb_i && we_i && adr_i == `CIDB_OFF_STAT && dat_i[0];
	// A request still waiting for its answer
	sequence s_req;
		cyc_i && stb_i && !ack_o && !err_o;
	endsequence
	// A window request while every transmit buffer is queued
	sequence s_win_req;
		s_req ##0 adr_i[7:4] == 4'h0 && adr_i[1:0] == 2'b00 &&
			tx_buffer_empty_flag_i == '0;
	endsequence
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held");
	a_ack_err_excl: assert property (!(ack_o && err_o))
		else $error("ack with err");
	a_answer_req: assert property ((ack_o || err_o) |-> cyc_i && stb_i)
		else $error("answer without request");
	a_bus_answer: assert property (s_req |-> ##[1:4] (ack_o || err_o))
		else $error("no answer");
	a_rx_rd_refused: assert property (
		s_win_req ##0 !we_i && !rx_buffer_full_flag_o |-> ##[1:4] err_o)
		else $error("rx read not refused");
	a_rx_wr_refused: assert property (
		s_win_req ##0 we_i |-> ##[1:4] err_o)
		else $error("rx write not refused");
	a_rxf_set: assert property (
		rx_buffer_full_flag_set_i |=> rx_buffer_full_flag_o)
		else $error("full flag not set");
	a_rxf_clear: assert property (
		$fell(rx_buffer_full_flag_o) |-> $past(clr_w) || $past(clr_w, 2))
		else $error("full flag dropped alone");
	a_fetch_answer: assert property (
		tx_fetch_i |-> ##[1:16] tx_valid_o)
		else $error("fetch unanswered");
endmodule // cidb_chk

bind cidb_top cidb_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o),
	.err_o(err_o), .rx_buffer_full_flag_set_i(rx_buffer_full_flag_set_i),
	.rx_buffer_full_flag_o(rx_buffer_full_flag_o), .tx_fetch_i(tx_fetch_i),
	.tx_valid_o(tx_valid_o),
	.tx_buffer_empty_flag_i(tx_buffer_empty_flag_i));

// file: bench/cidb_engine_model.sv
// Behavioural bit engine that stores and fetches identifiers
`timescale 1ns/1ns
// ==============================
// Engine model
module cidb_engine_model (
	// Clock
	input wire logic clk_i,
	// Receive store
	output logic rx_store_o,
	output logic [28:0] rx_id_o,
	output logic rx_ide_o,
	output logic rx_srr_o,
	output logic rx_rtr_o,
	output logic rxf_set_o,
	// Transmit fetch
	output logic tx_fetch_o,
	output logic [1:0] tx_fetch_buf_o,
	input wire logic tx_valid_i,
	input wire logic [31:0] tx_arb_i
);
	// Quiet at time zero
	initial begin
		{rx_store_o, rx_id_o, rx_ide_o, rx_srr_o, rx_rtr_o} = '0;
		{rxf_set_o, tx_fetch_o, tx_fetch_buf_o} = '0;
	end
	// Store a frame's fields as they came off the bus, then flag it
	task rx_frame(input logic [28:0] id, input logic ide, srr, rtr);
		begin
			rx_store_o <= 1'b1;
			rx_id_o <= id;
			rx_ide_o <= ide;
			rx_srr_o <= srr;
			rx_rtr_o <= rtr;
			@(posedge clk_i);
			// Released lines flip so a stale field cannot pass for a match
			rx_store_o <= 1'b0;
			{rx_id_o, rx_ide_o, rx_srr_o, rx_rtr_o} <= ~{id, ide, srr, rtr};
			rxf_set_o <= 1'b1;
			@(posedge clk_i);
			rxf_set_o <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	// Ask for a queued buffer; the wait is bounded
	task fetch(input logic [1:0] bn, output logic [31:0] arb, output logic ok);
		int i;
		begin
			ok = 1'b0;
			arb = '0;
			tx_fetch_o <= 1'b1;
			tx_fetch_buf_o <= bn;
			@(posedge clk_i);
			tx_fetch_o <= 1'b0;
			tx_fetch_buf_o <= ~bn;
			for (i = 0; i < 20 && !ok; i++) begin
				@(posedge clk_i);
				ok = tx_valid_i === 1'b1;
				arb = tx_arb_i;
			end
		end
	endtask
endmodule // cidb_engine_model

// file: bench/tb_cidb_top.sv
// Self-checking bench for the identifier buffer block
`timescale 1ns/1ns
`include "cidb_defines.vh"
// ==============================
// Bench top
module tb_cidb_top;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic ack_o, err_o, rxf_o, tx_valid_o, rx_st, rxf_set, fet, e, ok;
	logic rx_ide, rx_srr, rx_rtr, ide, srr, rtr;
	logic [7:0] adr_i = '0;
	logic [31:0] dat_i = '0, dat_o, tx_arb_o, q, p, mk, r32, a32;
	logic [28:0] rx_id, rid;
	logic [2:0] tx_empty = 3'h7;
	logic [1:0] fbuf;
	logic [4:0] alen;
	int fail_count = 0, n_checks = 0, k, j;
	// Free-running bus clock
	always #25 clk_i = ~clk_i;
	cidb_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.tx_buffer_empty_flag_i(tx_empty), .rx_buffer_full_flag_set_i(rxf_set),
		.rx_store_i(rx_st), .rx_id_i(rx_id), .rx_ide_i(rx_ide),
		.rx_srr_i(rx_srr), .rx_rtr_i(rx_rtr), .tx_fetch_i(fet),
		.tx_fetch_buf_i(fbuf), .tx_valid_o(tx_valid_o), .tx_arb_o(tx_arb_o),
		.tx_arb_len_o(alen), .rx_buffer_full_flag_o(rxf_o));
	cidb_engine_model eng_u (.clk_i(clk_i), .rx_store_o(rx_st),
		.rx_id_o(rx_id), .rx_ide_o(rx_ide), .rx_srr_o(rx_srr),
		.rx_rtr_o(rx_rtr), .rxf_set_o(rxf_set), .tx_fetch_o(fet),
		.tx_fetch_buf_o(fbuf), .tx_valid_i(tx_valid_o), .tx_arb_i(tx_arb_o));
	// Expected identifier bits in arbitration order
	function automatic logic [31:0] pack(logic [28:0] id, logic x, s, r);
		if (x) return {id[28:18], s, 1'b1, id[17:0], r};
		return {id[10:0], r, 1'b0, 19'h0};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// One classic cycle; the slave's pace decides, a bound cuts hangs
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		begin
			cyc_i <= 1;
			stb_i <= 1;
			we_i <= w;
			adr_i <= a;
			dat_i <= d;
			i = 0;
			do begin
				@(posedge clk_i);
				i++;
			end while (ack_o !== 1 && err_o !== 1 && i < 40);
			if (i >= 40) begin
				fail_count++;
				conclude;
			end
			q = dat_o;
			e = err_o;
			cyc_i <= 0;
			stb_i <= 0;
			@(posedge clk_i);
		end
	endtask
	// ==============================
	// Main sequence
	initial begin
		void'($urandom(47874));
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk(rxf_o, 0, "rx flag reset");
		chk(tx_valid_o, 0, "tx valid reset");
		$display("test reset done");
		wb(0, 8'h20, 0); // Unmapped place must still answer
		wb(1, `CIDB_OFF_SEL, 0);
		wb(1, `CIDB_OFF_ID0, 0);
		chk(e, 1, "write, none selected");
		for (k = 0; k < 6; k++) begin
			rid = k == 0 ? '1 : 29'($urandom);
			ide = ~k[0];
			rtr = 1'($urandom);
			p = pack(rid, ide, 1'b1, rtr);
			mk = ide ? '1 : 32'hfff80000;
			wb(1, `CIDB_OFF_SEL, 32'h1 << (k % 3));
			for (j = 0; j < 4; j++) wb(1, 8'(4 * j), {24'h0, p[31-8*j -: 8]});
			for (j = 0; j < 4; j++) begin
				wb(0, 8'(4 * j), 0);
				r32[31-8*j -: 8] = q[7:0];
			end
			chk(r32 & mk, p & mk, "id bytes");
			tx_empty[k % 3] <= 0;
			wb(1, `CIDB_OFF_ID0, 0);
			chk(e, 1, "write to queued buffer");
			eng_u.fetch(2'(k % 3), a32, ok);
			chk(ok, 1, "fetch answer");
			chk(a32 & mk, p & mk, "arb bits");
			chk(alen, ide ? 5'd31 : 5'd12, "arb length");
			wb(0, `CIDB_OFF_TXID, 0);
			chk(q & mk, p & mk, "arb word on bus");
			tx_empty[k % 3] <= 1;
		end
		$display("test transmit done");
		// Every transmit buffer queued: the window reaches only receive
		tx_empty <= 3'h0;
		for (k = 0; k < 4; k++) begin
			rid = 29'($urandom);
			{srr, rtr} = 2'($urandom);
			ide = k < 2;
			mk = ide ? '1 : 32'hfff80000;
			p = pack(rid, ide, srr, rtr);
			wb(0, `CIDB_OFF_ID1, 0);
			chk(e, 1, "read, rx empty");
			eng_u.rx_frame(rid, ide, srr, rtr);
			chk(rxf_o, 1, "rx flag set");
			wb(0, `CIDB_OFF_STAT, 0);
			chk(q[0], 1, "rx flag in status");
			for (j = 0; j < 4; j++) begin
				wb(0, 8'(4 * j), 0);
				r32[31-8*j -: 8] = q[7:0];
			end
			chk(r32 & mk, p & mk, "rx id");
			wb(1, `CIDB_OFF_ID0, ~p);
			chk(e, 1, "rx write");
			wb(0, `CIDB_OFF_ID0, 0);
			chk(q[7:0], p[31:24], "rx byte kept");
			wb(1, `CIDB_OFF_STAT, 1);
			chk(rxf_o, 0, "rx flag clear");
		end
		$display("test receive done");
		conclude;
	end
endmodule // tb_cidb_top
